// >>> rtl/tpm_pkg.sv
// package of register map, field layout and reset values for the prescaled modulo timer
package tpm_pkg;
   // ==========================================================
   // register word offsets (byte addresses on the bus)
   localparam logic [3:0] TPM_OFS_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] TPM_OFS_COUNTER_HIGH   = 4'h4;
   localparam logic [3:0] TPM_OFS_COUNTER_LOW    = 4'h8;
   localparam logic [3:0] TPM_OFS_MODULO_HIGH    = 4'hC;
   // modulo low sits past the 4-bit field, so the offset width is 5
   localparam logic [4:0] TPM_OFS_MODULO_LOW     = 5'h10;
   localparam logic [4:0] TPM_OFS_SYSTEM_CONTROL = 5'h14;
   // ==========================================================
   // status/control field positions
   localparam int TPM_BIT_WRAP_FLAG   = 7;
   localparam int TPM_BIT_WRAP_IRQ_EN = 6;
   localparam int TPM_BIT_COUNT_HALT  = 5;
   localparam int TPM_BIT_COUNT_RESET = 4;
   localparam int TPM_BIT_DIV_MSB     = 2;
   // system control register: break clear enable and break state readback
   localparam int TPM_BIT_BREAK_CLR_EN = 0;
   // ==========================================================
   // reset values, external clock select code and prescaler width
   localparam logic [2:0]  TPM_RST_DIVIDER_SELECT = 3'h0;
   localparam logic [15:0] TPM_RST_MODULO         = 16'hFFFF;
   localparam logic [15:0] TPM_RST_COUNTER        = 16'h0000;
   localparam logic [2:0]  TPM_SEL_EXT_CLOCK      = 3'h7;
   localparam int          TPM_PRESCALE_WIDTH     = 6;
endpackage

// >>> rtl/tpm_prescaler.sv
// prescaler that makes the counter increment enable from bus clock or external pin
`timescale 1ns/1ps
module tpm_prescaler
   import tpm_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       clear_div,
   input  wire logic       run,
   input  wire logic [2:0] divider_select,
   input  wire logic       ext_count_clock,
   output logic            tick
);
   logic [TPM_PRESCALE_WIDTH-1:0] div_reg;
   logic                          ext_sync1_reg;
   logic                          ext_sync2_reg;
   logic                          ext_prev_reg;
   logic                          div_hit;
   logic [TPM_PRESCALE_WIDTH:0]   div_mask;

   // ==========================================================
   // divider: clear on counter reset, frozen while not running
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= '0;
      end else if (clear_div) begin
         div_reg <= '0;
      end else if (run) begin
         div_reg <= div_reg + 6'h01;
      end
   end

   // two-stage synchroniser on the pin, edge seen after the second stage only
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext_sync1_reg <= 1'b0;
         ext_sync2_reg <= 1'b0;
         ext_prev_reg  <= 1'b0;
      end else begin
         ext_sync1_reg <= ext_count_clock;
         ext_sync2_reg <= ext_sync1_reg;
         ext_prev_reg  <= ext_sync2_reg;
      end
   end

   // a code n ticks when the low n bits of the divider are all ones
   assign div_mask = (7'h01 << divider_select) - 7'h01;
   assign div_hit  = ((div_reg & div_mask[TPM_PRESCALE_WIDTH-1:0]) == div_mask[TPM_PRESCALE_WIDTH-1:0]);

   // select source; external edge gives one bus-cycle enable
   always_comb begin
      if (divider_select == TPM_SEL_EXT_CLOCK) begin
         tick = run && ext_sync2_reg && !ext_prev_reg;
      end else begin
         tick = run && div_hit;
      end
   end
endmodule

// >>> rtl/tpm_timer.sv
// prescaled 16-bit modulo timer core with Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module tpm_timer
   import tpm_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [1:0]  avs_response,
   input  wire logic        break_active,
   input  wire logic        low_power_stop,
   input  wire logic        ext_count_clock,
   output logic             ext_pin_input_force,
   output logic             wrap_irq,
   output logic      [15:0] counter_value,
   output logic             wrap_event
);
   // ==========================================================
   // state
   logic [15:0] counter_reg;
   logic [15:0] modulo_reg;
   logic [7:0]  low_latch_reg;
   logic        low_latched_reg;
   logic        wrap_flag_reg;
   logic        wrap_irq_enable_reg;
   logic        count_halt_reg;
   logic [2:0]  divider_select_reg;
   logic        count_reset_reg;
   logic        clear_armed_reg;
   logic        modulo_hold_reg;
   logic        break_clear_enable_reg;
   logic        ack_reg;
   logic        tick;
   logic        run;
   logic        wrap_now;
   logic        take;
   logic        wr_ok;
   logic        rd_ok;
   logic        flag_writes_ok;
   logic [31:0] rd_data;

   // one access per two cycles: request taken, then waitrequest drops
   assign take  = (avs_read || avs_write) && !ack_reg && !low_power_stop;
   assign wr_ok = take && avs_write && avs_byteenable[0];
   assign rd_ok = take && avs_read;
   // status bits touched by software only outside a break or with clear enable
   assign flag_writes_ok = !break_active || break_clear_enable_reg;

   // decode helper used by every register write and read side effect
   function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
      hit = (addr == ofs);
   endfunction

   // counting halted by halt bit, break or low-power stop
   assign run = !count_halt_reg && !break_active && !low_power_stop;

   // ==========================================================
   // prescaler
   tpm_prescaler u_prescaler (
      .clk_sys         (clk_sys),
      .rst_b           (rst_b),
      .clear_div       (count_reset_reg),
      .run             (run),
      .divider_select  (divider_select_reg),
      .ext_count_clock (ext_count_clock),
      .tick            (tick)
   );

   assign wrap_now = tick && (counter_reg == modulo_reg) && !count_reset_reg;

   // ==========================================================
   // counter: wraps at modulo, cleared by reset bit
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         counter_reg <= TPM_RST_COUNTER;
      end else if (count_reset_reg) begin
         counter_reg <= TPM_RST_COUNTER;
      end else if (wrap_now) begin
         counter_reg <= TPM_RST_COUNTER;
      end else if (tick) begin
         counter_reg <= counter_reg + 16'h0001;
      end
   end

   // reset bit is a one-cycle self-clearing strobe, never read back
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         count_reset_reg <= 1'b0;
      end else begin
         count_reset_reg <= wr_ok && hit(avs_address, {1'b0, TPM_OFS_STATUS_CONTROL})
                            && avs_writedata[TPM_BIT_COUNT_RESET];
      end
   end

   // ==========================================================
   // control fields of status/control
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrap_irq_enable_reg <= 1'b0;
         count_halt_reg      <= 1'b1;
         divider_select_reg  <= TPM_RST_DIVIDER_SELECT;
      end else if (wr_ok && hit(avs_address, {1'b0, TPM_OFS_STATUS_CONTROL})) begin
         wrap_irq_enable_reg <= avs_writedata[TPM_BIT_WRAP_IRQ_EN];
         count_halt_reg      <= avs_writedata[TPM_BIT_COUNT_HALT];
         divider_select_reg  <= avs_writedata[TPM_BIT_DIV_MSB:0];
      end
   end

   // system-level break clear enable, defaults low
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         break_clear_enable_reg <= 1'b0;
      end else if (wr_ok && hit(avs_address, TPM_OFS_SYSTEM_CONTROL)) begin
         break_clear_enable_reg <= avs_writedata[TPM_BIT_BREAK_CLR_EN];
      end
   end

   // ==========================================================
   // wrap flag with two-step clear; a new wrap outside a modulo update wins and voids the armed clear
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrap_flag_reg   <= 1'b0;
         clear_armed_reg <= 1'b0;
      end else if (wrap_now && !modulo_hold_reg) begin
         wrap_flag_reg   <= 1'b1;
         clear_armed_reg <= 1'b0;
      end else if (flag_writes_ok) begin
         // armed state survives a protected break untouched, so the write finishes later
         if (wr_ok && hit(avs_address, {1'b0, TPM_OFS_STATUS_CONTROL})) begin
            if (clear_armed_reg && !avs_writedata[TPM_BIT_WRAP_FLAG]) begin
               wrap_flag_reg <= 1'b0;
            end
            clear_armed_reg <= 1'b0;
         end else if (rd_ok && hit(avs_address, {1'b0, TPM_OFS_STATUS_CONTROL}) && wrap_flag_reg) begin
            clear_armed_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // modulo registers; high write holds off flag until low write
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         modulo_reg      <= TPM_RST_MODULO;
         modulo_hold_reg <= 1'b0;
      end else if (wr_ok && hit(avs_address, {1'b0, TPM_OFS_MODULO_HIGH})) begin
         modulo_reg[15:8] <= avs_writedata[7:0];
         modulo_hold_reg  <= 1'b1;
      end else if (wr_ok && hit(avs_address, TPM_OFS_MODULO_LOW)) begin
         modulo_reg[7:0]  <= avs_writedata[7:0];
         modulo_hold_reg  <= 1'b0;
      end
   end

   // ==========================================================
   // low byte latch; buffer is refreshed only once the low byte has been read
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         low_latch_reg   <= 8'h00;
         low_latched_reg <= 1'b0;
      end else if (rd_ok && hit(avs_address, {1'b0, TPM_OFS_COUNTER_HIGH}) && !low_latched_reg) begin
         low_latch_reg   <= counter_reg[7:0];
         low_latched_reg <= 1'b1;
      end else if (rd_ok && hit(avs_address, {1'b0, TPM_OFS_COUNTER_LOW})) begin
         low_latched_reg <= 1'b0;
      end
   end

   // ==========================================================
   // read mux, unmapped addresses read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (avs_address)
         {1'b0, TPM_OFS_STATUS_CONTROL}: begin
            rd_data[TPM_BIT_WRAP_FLAG]     = wrap_flag_reg;
            rd_data[TPM_BIT_WRAP_IRQ_EN]   = wrap_irq_enable_reg;
            rd_data[TPM_BIT_COUNT_HALT]    = count_halt_reg;
            rd_data[TPM_BIT_DIV_MSB:0]     = divider_select_reg; // reset bit reads zero
         end
         {1'b0, TPM_OFS_COUNTER_HIGH}: rd_data[7:0] = counter_reg[15:8];
         {1'b0, TPM_OFS_COUNTER_LOW}:  rd_data[7:0] = low_latched_reg ? low_latch_reg : counter_reg[7:0];
         {1'b0, TPM_OFS_MODULO_HIGH}:  rd_data[7:0] = modulo_reg[15:8];
         TPM_OFS_MODULO_LOW:           rd_data[7:0] = modulo_reg[7:0];
         TPM_OFS_SYSTEM_CONTROL: begin
            rd_data[TPM_BIT_BREAK_CLR_EN]     = break_clear_enable_reg;
            rd_data[TPM_BIT_BREAK_CLR_EN + 1] = break_active;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // bus answer: waitrequest high except in the acknowledge cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         avs_response    <= 2'b00;
      end else begin
         ack_reg         <= take;
         avs_waitrequest <= !take;
         if (rd_ok) begin
            avs_readdata <= rd_data;
         end
         avs_response    <= 2'b00;
      end
   end

   // ==========================================================
   // outputs registered: interrupt, pin direction override, counter link
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrap_irq            <= 1'b0;
         ext_pin_input_force <= 1'b0;
         counter_value       <= TPM_RST_COUNTER;
         wrap_event          <= 1'b0;
      end else begin
         wrap_irq            <= wrap_flag_reg && wrap_irq_enable_reg;
         ext_pin_input_force <= (divider_select_reg == TPM_SEL_EXT_CLOCK);
         counter_value       <= counter_reg;
         wrap_event          <= wrap_now;
      end
   end

   // ==========================================================
   // checks
   break_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      break_active && $past(break_active) && !$past(count_reset_reg) |-> $stable(counter_reg))
      else $error("counter moved during break");
   halt_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      count_halt_reg && $past(count_halt_reg) && !$past(count_reset_reg) |-> $stable(counter_reg))
      else $error("counter moved while halted");
   reset_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      count_reset_reg |=> counter_reg == 16'h0000)
      else $error("counter not cleared by reset bit");
   wrap_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wrap_now && !modulo_hold_reg |=> wrap_flag_reg && counter_reg == 16'h0000)
      else $error("wrap did not set flag");
   break_protect_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      break_active && !break_clear_enable_reg && !wrap_now |=> !$fell(wrap_flag_reg))
      else $error("flag cleared in protected break");
   clear_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(wrap_flag_reg) |-> $past(clear_armed_reg) && $past(wr_ok))
      else $error("flag cleared without read then write");
   irq_link_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wrap_flag_reg && wrap_irq_enable_reg |=> wrap_irq)
      else $error("interrupt missing");
   mod_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      modulo_hold_reg |=> !$rose(wrap_flag_reg))
      else $error("flag set during modulo update");
   latch_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      low_latched_reg && !(rd_ok && hit(avs_address, {1'b0, TPM_OFS_COUNTER_LOW})) |=> $stable(low_latch_reg))
      else $error("latched low byte changed");
   bus_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      take |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");
   // pin direction, prescaler source and external edge width
   ext_force_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      divider_select_reg == TPM_SEL_EXT_CLOCK |=> ext_pin_input_force)
      else $error("pin not forced to input");
   ext_release_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      divider_select_reg != TPM_SEL_EXT_CLOCK |=> !ext_pin_input_force)
      else $error("pin force left on");
   div_one_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run && divider_select_reg == TPM_RST_DIVIDER_SELECT |-> tick)
      else $error("divide by one missed a cycle");
   ext_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tick && divider_select_reg == TPM_SEL_EXT_CLOCK |=> !tick || divider_select_reg != TPM_SEL_EXT_CLOCK)
      else $error("pin edge gave more than one increment");
   // low-power stop and the combined halt plus counter reset
   stop_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(low_power_stop) && !$past(count_reset_reg) |-> $stable(counter_reg))
      else $error("counter moved in low-power stop");
   stop_regs_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(low_power_stop) |-> $stable(modulo_reg) && $stable(wrap_flag_reg) && $stable(count_halt_reg))
      else $error("register changed in low-power stop");
   halt_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      count_halt_reg && count_reset_reg |=> counter_reg == TPM_RST_COUNTER ##1 counter_reg == TPM_RST_COUNTER)
      else $error("halted counter left zero");
   strobe_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      count_reset_reg |=> !count_reset_reg)
      else $error("reset strobe did not self-clear");
   // flag clearing steps and the low byte buffer
   arm_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      break_active && !break_clear_enable_reg |=> $stable(clear_armed_reg))
      else $error("armed clear changed in protected break");
   one_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_ok && hit(avs_address, {1'b0, TPM_OFS_STATUS_CONTROL}) && avs_writedata[TPM_BIT_WRAP_FLAG]
      |=> !$fell(wrap_flag_reg)) else $error("writing one cleared the flag");
   latch_take_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rd_ok && hit(avs_address, {1'b0, TPM_OFS_COUNTER_HIGH}) |=> low_latched_reg)
      else $error("high read did not latch low byte");
   // registered outputs trail the core by one cycle; bus answer is fixed
   event_link_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wrap_event == $past(wrap_now))
      else $error("wrap pulse out of step");
   count_link_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      counter_value == $past(counter_reg))
      else $error("counter copy out of step");
   irq_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !wrap_flag_reg || !wrap_irq_enable_reg |=> !wrap_irq)
      else $error("interrupt without flag and enable");
   resp_okay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      avs_response == 2'h0)
      else $error("bus response not okay");
   rd_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      avs_readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   wrap_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(wrap_flag_reg));
   clear_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(wrap_flag_reg));
   break_clear_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      break_active && $fell(wrap_flag_reg));
   ext_tick_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
      tick && divider_select_reg == TPM_SEL_EXT_CLOCK);
   mod_hold_c: cover property (@(posedge clk_sys) disable iff (!rst_b) wrap_now && modulo_hold_reg);
endmodule

// >>> tb/tpm_timer_tb_top.sv
// self-checking testbench for the prescaled modulo timer
`timescale 1ns/1ps
module tpm_timer_tb_top;
   import tpm_pkg::*;
   // ==========================================================
   // signals
   logic        clk_sys;
   logic        rst_b;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  avs_response;
   logic        break_active;
   logic        low_power_stop;
   logic        ext_count_clock;
   logic        ext_pin_input_force;
   logic        wrap_irq;
   logic [15:0] counter_value;
   logic        wrap_event;
   int          n_mismatch;
   int          check_count;
   int          n_wrap_event;
   logic [15:0] c0;

   tpm_timer DUT (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .break_active(break_active), .low_power_stop(low_power_stop), .ext_count_clock(ext_count_clock),
      .ext_pin_input_force(ext_pin_input_force), .wrap_irq(wrap_irq), .counter_value(counter_value),
      .wrap_event(wrap_event)
   );

   // ==========================================================
   // clock, 200 MHz
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // request held until waitrequest is sampled low, then released; one idle edge follows
   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
      avs_address    <= a;
      avs_writedata  <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic expect_reg(input logic [4:0] a, input logic [7:0] exp);
      logic [31:0] rd;
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      rd = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk_sys);
      check(rd, {24'h000000, exp});
   endtask

   // pin pulses slow enough for the synchroniser, then settle past its latency
   task automatic pulses(input int n);
      for (int i = 0; i < n; i++) begin
         ext_count_clock <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ext_count_clock <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      repeat (4) @(posedge clk_sys);
   endtask

   // count wrap pulses one edge after the wrap they stand for; cleared while reset is low
   always @(posedge clk_sys) begin
      if (rst_b !== 1'b1) begin
         n_wrap_event <= 0;
      end else if (wrap_event === 1'b1) begin
         n_wrap_event <= n_wrap_event + 1;
      end
   end

   // ==========================================================
   // watchdog: the whole sequence needs under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      print_verdict();
   end

   // ==========================================================
   // main sequence
   initial begin
      n_mismatch = 0;
      check_count = 0;
      rst_b = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      break_active = 1'b0;
      low_power_stop = 1'b0;
      ext_count_clock = 1'b0;
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      // reset values, counter halted out of reset, unmapped place
      expect_reg(5'h00, 8'h20);
      expect_reg(5'h04, 8'h00);
      expect_reg(5'h08, 8'h00);
      expect_reg(5'h0C, 8'hFF);
      expect_reg(5'h10, 8'hFF);
      expect_reg(5'h14, 8'h00);
      expect_reg(5'h1C, 8'h00);
      repeat (20) @(posedge clk_sys);
      check(counter_value, 32'h0);
      // every internal divider: a window of 8 periods holds exactly 8 increments
      for (int s = 0; s < 7; s++) begin
         wr(5'h00, 8'h30 | 8'(s));
         wr(5'h00, 8'(s));
         repeat (4) @(posedge clk_sys);
         c0 = counter_value;
         repeat (8 << s) @(posedge clk_sys);
         check(counter_value - c0, 32'h8);
         check(ext_pin_input_force, 32'h0);
      end
      // halt and counter reset together leave zero; other registers kept
      wr(5'h00, 8'h30);
      expect_reg(5'h04, 8'h00);
      expect_reg(5'h08, 8'h00);
      expect_reg(5'h00, 8'h20);
      expect_reg(5'h0C, 8'hFF);
      // external pin counting and low-byte latching
      wr(5'h00, 8'h07);
      check(ext_pin_input_force, 32'h1);
      pulses(3);
      check(counter_value, 32'h3);
      expect_reg(5'h04, 8'h00);
      pulses(2);
      expect_reg(5'h04, 8'h00);
      expect_reg(5'h08, 8'h03);
      expect_reg(5'h08, 8'h05);
      wr(5'h04, 8'h55);
      expect_reg(5'h08, 8'h05);
      // break and low-power stop freeze the count
      break_active <= 1'b1;
      pulses(2);
      check(counter_value, 32'h5);
      expect_reg(5'h04, 8'h00);
      expect_reg(5'h08, 8'h05);
      break_active <= 1'b0;
      low_power_stop <= 1'b1;
      pulses(2);
      check(counter_value, 32'h5);
      low_power_stop <= 1'b0;
      pulses(1);
      check(counter_value, 32'h6);
      // modulo 2 with interrupt enable: wrap after three edges
      wr(5'h00, 8'h37);
      wr(5'h0C, 8'h00);
      wr(5'h10, 8'h02);
      wr(5'h00, 8'h47);
      pulses(3);
      check(wrap_irq, 32'h1);
      check(counter_value, 32'h0);
      expect_reg(5'h00, 8'hC7);
      wr(5'h00, 8'hC7);
      expect_reg(5'h00, 8'hC7);
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h07);
      check(wrap_irq, 32'h0);
      // a zero write without the read step does not clear
      pulses(3);
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h87);
      // armed before the break, completed after it
      break_active <= 1'b1;
      expect_reg(5'h00, 8'h87);
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h87);
      break_active <= 1'b0;
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h07);
      // protected break: accesses leave the flag alone
      pulses(3);
      break_active <= 1'b1;
      expect_reg(5'h00, 8'h87);
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h87);
      break_active <= 1'b0;
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h87);
      // clear enabled: cleared in the break, stays cleared
      wr(5'h14, 8'h01);
      break_active <= 1'b1;
      expect_reg(5'h14, 8'h03);
      expect_reg(5'h00, 8'h87);
      wr(5'h00, 8'h07);
      expect_reg(5'h00, 8'h07);
      break_active <= 1'b0;
      expect_reg(5'h00, 8'h07);
      wr(5'h14, 8'h00);
      // high modulo byte alone suppresses the flag until the low byte lands
      wr(5'h00, 8'h17);
      wr(5'h0C, 8'h00);
      pulses(3);
      expect_reg(5'h00, 8'h07);
      wr(5'h10, 8'h02);
      pulses(3);
      expect_reg(5'h00, 8'h87);
      // write without its byte lane is ignored
      wr(5'h10, 8'h05, 4'h0);
      expect_reg(5'h10, 8'h02);
      check(n_wrap_event, 32'h5);
      check(avs_response, 32'h0);
      print_verdict();
   end
endmodule
